// *** rtl/pulse_measure_timer_defines.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef PULSE_MEASURE_TIMER_DEFINES_SVH
`define PULSE_MEASURE_TIMER_DEFINES_SVH

`define PMT_ADDR_W          12
`define PMT_OFF_CTRL        12'h000
`define PMT_OFF_SEL         12'h004
`define PMT_OFF_CNT_LOW     12'h008
`define PMT_OFF_CNT_HIGH    12'h00C
`define PMT_OFF_CNT_UPPER   12'h010
`define PMT_OFF_PR_LOW      12'h014
`define PMT_OFF_PR_HIGH     12'h018
`define PMT_OFF_PR_UPPER    12'h01C
`define PMT_OFF_PW_CAP      12'h020
`define PMT_OFF_PER_CAP     12'h024
`define PMT_OFF_STATUS      12'h028
`define PMT_OFF_IRQ_CLR     12'h02C
`define PMT_OFF_IRQ_EN      12'h030
`define PMT_OFF_LEVELS      12'h034

// Control register fields
`define PMT_CTRL_EN         0
`define PMT_CTRL_GO         1
`define PMT_CTRL_SINGLE     2
`define PMT_CTRL_POL        3
`define PMT_CTRL_W16        4
`define PMT_CTRL_MODE_LSB   5

// Source select fields, two bits each
`define PMT_SEL_CLK_LSB     0
`define PMT_SEL_GATE_LSB    2
`define PMT_SEL_SIG_LSB     4
`define PMT_SEL_WIN_LSB     6

// Status bits
`define PMT_ST_MATCH        0
`define PMT_ST_ACQ          1

`define PMT_PR_RESET        24'hFFFFFF
`define PMT_CNT_RESTART     24'h000001

`endif

// *** rtl/pulse_measure_timer_pkg.sv ***
// Types shared by the pulse measure timer
package pulse_measure_timer_pkg;

	typedef enum logic [1:0] {
		mode_timer,
		mode_duty,
		mode_relative
	} measure_mode_t;

	typedef struct packed {
		logic [1:0] win_sel;
		logic [1:0] sig_sel;
		logic [1:0] gate_sel;
		logic [1:0] clk_sel;
	} source_sel_t;

	typedef struct packed {
		logic acq;
		logic match;
	} irq_bits_t;

endpackage

// *** rtl/pulse_measure_timer.sv ***
// Signal measurement timer with capture, period match and APB registers
//
// What this block does
// - 24-bit counter readable and writable as low, high and upper bytes.
// - Optional mode makes the counter 16 bits wide instead of 24.
// - Two 24-bit capture registers hold pulse width and period.
// - 24-bit period-match value split in three readable writable bytes.
// - Interrupt request raised when counter reaches the period-match value.
// - Separate interrupt request raised when an acquisition completes.
// - Software selects clock, gate and measured-signal sources.
// - Several modes, including relative timing between edges of two signals.
// - Software can read present levels of selected input signals.
// - Duty mode measures high or low time per polarity, and period, in timer clocks.
// - Duty mode falling edge loads counter into pulse-width capture.
// - Duty mode rising edge loads period capture, restarts counter at one.
// - Single acquisition clears go bit on measured-input rise (duty mode) or window rise (relative mode).
`timescale 1ns/1ns
`include "pulse_measure_timer_defines.svh"

module pulse_measure_timer
	import pulse_measure_timer_pkg::*;
#(
	parameter int CNT_W   = 24,
	parameter int N_SRC   = 4
)(
	input  wire logic               ref_clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [11:0]        paddr_i,
	input  wire logic [31:0]        pwdata_i,
	output logic      [31:0]        prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire logic [N_SRC-1:0]   clk_src_i,
	input  wire logic [N_SRC-1:0]   gate_src_i,
	input  wire logic [N_SRC-1:0]   signal_src_i,
	output logic                    irq_o
);

	// Refuse widths that the byte map and the two-bit selects cannot serve
	if (CNT_W != 24 || N_SRC != 4)
	begin : g_bad_params
		$error("pulse_measure_timer supports CNT_W 24 and N_SRC 4 only");
	end

	// Bus decode
	logic apb_wr;
	assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;

	// True when the bus address selects the given register offset
	function automatic logic hit(input logic [11:0] off);
		hit = (paddr_i == off);
	endfunction

	// Register state
	logic [7:0]    ctrl;
	source_sel_t   sel;
	logic [23:0]   counter;
	logic [23:0]   period_match_value;
	logic [23:0]   pulse_width_capture;
	logic [23:0]   period_capture;
	irq_bits_t     status;
	irq_bits_t     irq_en;
	logic [2:0]    prev_in;
	logic [2:0]    levels;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic          irq;

	// Next values of the register state
	logic [7:0]    next_ctrl;
	source_sel_t   next_sel;
	logic [23:0]   next_counter;
	logic [23:0]   next_period_match_value;
	logic [23:0]   next_pulse_width_capture;
	logic [23:0]   next_period_capture;
	irq_bits_t     next_status;
	irq_bits_t     next_irq_en;
	logic [2:0]    next_prev_in;
	logic [31:0]   next_prdata;
	logic          next_pready;
	logic          next_pslverr;
	logic          next_irq;

	// Source selection
	// Each two-bit select field picks one of the four lines of its group
	logic          tclk;
	logic          gate;
	logic          sig;
	logic          win;
	assign tclk = clk_src_i[sel.clk_sel];
	assign gate = gate_src_i[sel.gate_sel];
	assign sig  = signal_src_i[sel.sig_sel];
	assign win  = signal_src_i[sel.win_sel];
	assign levels = {win, sig, gate};

	// Edge detection of timer clock, measured input and window input
	// Edges are seen in the clock in which the pin changes, with no lag
	// A polarity change alone looks like one edge; change it while stopped
	logic          tick;
	logic          sig_pol;
	logic          sig_rise;
	logic          sig_fall;
	logic          win_rise;
	assign tick     = tclk && !prev_in[0];
	assign sig_pol  = ctrl[`PMT_CTRL_POL] ? !sig : sig;
	assign sig_rise = sig_pol && !prev_in[1];
	assign sig_fall = !sig_pol && prev_in[1];
	assign win_rise = win && !prev_in[2];

	// Active width mask
	logic [23:0]   cnt_mask;
	assign cnt_mask = ctrl[`PMT_CTRL_W16] ? 24'h00FFFF : 24'hFFFFFF;

	// Counting needs enable, go and the selected gate all high
	logic          running;
	logic          match;
	measure_mode_t mode;
	assign mode    = measure_mode_t'(ctrl[`PMT_CTRL_MODE_LSB +: 2]);
	assign running = ctrl[`PMT_CTRL_EN] && ctrl[`PMT_CTRL_GO] && gate;
	assign match   = running && tick &&
		((counter & cnt_mask) == (period_match_value & cnt_mask));

	// Next-state logic for counter, captures, flags and bus answer
	always_comb
	begin
		irq_bits_t ev;
		ev                       = '0;
		next_ctrl                = ctrl;
		next_sel                 = sel;
		next_counter             = counter;
		next_period_match_value  = period_match_value;
		next_pulse_width_capture = pulse_width_capture;
		next_period_capture      = period_capture;
		next_irq_en              = irq_en;
		next_prev_in             = {win, sig_pol, tclk};
		next_pready              = psel_i && !penable_i;
		next_pslverr             = 1'b0;
		next_prdata              = 32'h00000000;

		// Counting on each rising edge of the timer clock
		if (running && tick)
		begin
			if (match)
			begin
				ev.match     = 1'b1;
				next_counter = 24'h000000;
			end
			else
				next_counter = (counter + 24'h000001) & cnt_mask;
		end

		// Measurement modes
		if (running)
		begin
			unique case (mode)
				mode_duty:
				begin
					if (sig_fall)
						next_pulse_width_capture = counter;
					if (sig_rise)
					begin
						next_period_capture = counter;
						next_counter        = `PMT_CNT_RESTART;
						ev.acq              = 1'b1;
						if (ctrl[`PMT_CTRL_SINGLE])
							next_ctrl[`PMT_CTRL_GO] = 1'b0;
					end
				end
				mode_relative:
				begin
					if (sig_rise)
						next_counter = `PMT_CNT_RESTART;
					if (win_rise)
					begin
						next_pulse_width_capture = counter;
						ev.acq                   = 1'b1;
						if (ctrl[`PMT_CTRL_SINGLE])
							next_ctrl[`PMT_CTRL_GO] = 1'b0;
					end
				end
				default:
				begin
					if (sig_rise)
						next_period_capture = counter;
				end
			endcase
		end

		// Register writes
		// A write to the counter lands after counting, so software wins
		if (apb_wr)
		begin
			if (hit(`PMT_OFF_CTRL))
				next_ctrl = pwdata_i[7:0];
			if (hit(`PMT_OFF_SEL))
				next_sel = source_sel_t'(pwdata_i[7:0]);
			if (hit(`PMT_OFF_CNT_LOW))
				next_counter[7:0] = pwdata_i[7:0];
			if (hit(`PMT_OFF_CNT_HIGH))
				next_counter[15:8] = pwdata_i[7:0];
			if (hit(`PMT_OFF_CNT_UPPER))
				next_counter[23:16] = pwdata_i[7:0];
			if (hit(`PMT_OFF_PR_LOW))
				next_period_match_value[7:0] = pwdata_i[7:0];
			if (hit(`PMT_OFF_PR_HIGH))
				next_period_match_value[15:8] = pwdata_i[7:0];
			if (hit(`PMT_OFF_PR_UPPER))
				next_period_match_value[23:16] = pwdata_i[7:0];
			if (hit(`PMT_OFF_IRQ_EN))
				next_irq_en = irq_bits_t'(pwdata_i[1:0]);
		end

		// Sticky status, set wins over clear
		next_status = status;
		if (apb_wr && hit(`PMT_OFF_IRQ_CLR))
			next_status = irq_bits_t'(status & ~pwdata_i[1:0]);
		next_status = irq_bits_t'(next_status | ev);
		// Built from next values so the interrupt tracks status without extra lag
		next_irq    = |(next_status & next_irq_en);

		// Read data, sampled during setup cycle
		if (psel_i && !penable_i && !pwrite_i)
		begin
			unique case (paddr_i)
				`PMT_OFF_CTRL:      next_prdata = {24'h000000, ctrl};
				`PMT_OFF_SEL:       next_prdata = {24'h000000, sel};
				`PMT_OFF_CNT_LOW:   next_prdata = {24'h000000, counter[7:0]};
				`PMT_OFF_CNT_HIGH:  next_prdata = {24'h000000, counter[15:8]};
				`PMT_OFF_CNT_UPPER: next_prdata = {24'h000000, counter[23:16]};
				`PMT_OFF_PR_LOW:    next_prdata = {24'h000000, period_match_value[7:0]};
				`PMT_OFF_PR_HIGH:   next_prdata = {24'h000000, period_match_value[15:8]};
				`PMT_OFF_PR_UPPER:  next_prdata = {24'h000000, period_match_value[23:16]};
				`PMT_OFF_PW_CAP:    next_prdata = {8'h00, pulse_width_capture};
				`PMT_OFF_PER_CAP:   next_prdata = {8'h00, period_capture};
				`PMT_OFF_STATUS:    next_prdata = {30'h00000000, status};
				`PMT_OFF_IRQ_EN:    next_prdata = {30'h00000000, irq_en};
				`PMT_OFF_LEVELS:    next_prdata = {29'h00000000, levels};
				`PMT_OFF_IRQ_CLR:   next_prdata = 32'h00000000;
				default:            next_pslverr = 1'b1;
			endcase
		end
		else if (psel_i && !penable_i)
		begin
			next_prdata  = 32'h00000000;
			next_pslverr = 1'b0;
		end
		// Hold the answer should a wait state ever be inserted
		else if (psel_i && penable_i && !pready_o)
		begin
			next_prdata  = prdata;
			next_pslverr = pslverr;
		end
	end

	// State registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl                <= 8'h00;
			sel                 <= '0;
			counter             <= 24'h000000;
			period_match_value  <= `PMT_PR_RESET;
			pulse_width_capture <= 24'h000000;
			period_capture      <= 24'h000000;
			status              <= '0;
			irq_en              <= '0;
			prev_in             <= 3'h0;
			prdata              <= 32'h00000000;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			irq                 <= 1'b0;
		end
		else
		begin
			ctrl                <= next_ctrl;
			sel                 <= next_sel;
			counter             <= next_counter;
			period_match_value  <= next_period_match_value;
			pulse_width_capture <= next_pulse_width_capture;
			period_capture      <= next_period_capture;
			status              <= next_status;
			irq_en              <= next_irq_en;
			prev_in             <= next_prev_in;
			prdata              <= next_prdata;
			pready              <= next_pready;
			pslverr             <= next_pslverr;
			irq                 <= next_irq;
		end
	end

	// Outputs come straight from their flip-flops
	assign prdata_o  = prdata;
	assign pready_o  = pready;
	assign pslverr_o = pslverr;
	assign irq_o     = irq;

endmodule // pulse_measure_timer

// *** test/pulse_measure_timer_sva.sv ***
// Checker on the bus and interrupt ports of the pulse measure timer
`timescale 1ns/1ns
module pulse_measure_timer_sva (
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        irq_o
);
	logic setup;
	logic mapped;
	logic wdone;
	logic pr_addr;
	// Transfer phase and address decode
	assign setup   = psel_i && !penable_i;
	assign mapped  = paddr_i <= 12'h034 && paddr_i[1:0] == 2'b00;
	assign wdone   = psel_i && penable_i && pready_o && pwrite_i;
	assign pr_addr = paddr_i >= 12'h014 && paddr_i <= 12'h01C;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_ready_after_setup: assert property (setup |=> pready_o)
		else $error("ready did not follow setup");
	a_ready_single: assert property (pready_o |=> !pready_o)
		else $error("ready stood longer than one cycle");
	a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside an access phase");
	a_err_unmapped: assert property (setup && !pwrite_i && !mapped |=> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped read not refused");
	a_err_mapped: assert property (setup && mapped |=> !pslverr_o)
		else $error("mapped access refused");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_byte_readback: assert property (setup && !pwrite_i && pr_addr && $past(wdone)
		&& $past(paddr_i) == paddr_i |=> prdata_o[7:0] == $past(pwdata_i[7:0], 2))
		else $error("match byte did not read back");
	a_irq_masked: assert property (wdone && paddr_i == 12'h030 && pwdata_i[1:0] == 2'b00
		|-> ##2 !irq_o)
		else $error("interrupt stayed high when masked");
endmodule // pulse_measure_timer_sva

// *** test/signal_source_model.sv ***
// Model of the clock, gate and measured sources
`timescale 1ns/1ns
module signal_source_model (
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] hi_len_i,
	input  wire logic [7:0] lo_len_i,
	input  wire logic [3:0] gate_lvl_i,
	output logic      [3:0] clk_src_o,
	output logic      [3:0] gate_src_o,
	output logic      [3:0] signal_src_o
);
	logic [7:0] run = 8'h00;
	logic [7:0] dly = 8'h00;
	logic       sig = 1'b0;
	logic [3:0] div = 4'h0;
	// Divided clocks, a high then low waveform and a copy delayed 8 cycles
	always @(posedge ref_clk_i)
	begin
		div <= div + 4'h1;
		run <= (run + 8'h1 >= hi_len_i + lo_len_i) ? 8'h00 : run + 8'h1;
		sig <= run < hi_len_i;
		dly <= {dly[6:0], sig};
	end
	// Clock and signal lines carry moving patterns; gate lines carry fixed levels
	assign clk_src_o    = div;
	assign gate_src_o   = gate_lvl_i;
	assign signal_src_o = {~dly[7], ~sig, dly[7], sig};
endmodule // signal_source_model

// *** test/pulse_measure_timer_test.sv ***
// Bench for the pulse measure timer
`timescale 1ns/1ns
`include "pulse_measure_timer_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pulse_measure_timer_test;
	import pulse_measure_timer_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [11:0] paddr_i   = 12'h000;
	logic [31:0] pwdata_i  = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        irq_o;
	logic [3:0]  clk_src_i;
	logic [3:0]  gate_src_i;
	logic [3:0]  signal_src_i;
	logic [7:0]  hi       = 8'h0A;
	logic [7:0]  lo       = 8'h0A;
	logic [3:0]  gate_lvl = 4'h0;
	logic [31:0] seed     = 32'hFEB2F844;
	logic [31:0] q;
	logic [31:0] d;
	int          n_fail   = 0;
	int          checked  = 0;
	int          cyc      = 0;
	int          n;
	int          i;
	pulse_measure_timer pulse_measure_timer_i (.ref_clk_i, .reset_n_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .clk_src_i,
		.gate_src_i, .signal_src_i, .irq_o);
	signal_source_model signal_source_model_i (.ref_clk_i, .hi_len_i(hi), .lo_len_i(lo),
		.gate_lvl_i(gate_lvl), .clk_src_o(clk_src_i), .gate_src_o(gate_src_i),
		.signal_src_o(signal_src_i));
	// Clock and hang guard
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			finish_test();
		end
	end
	// Random source and a capture estimate within one tick
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic near(input logic [31:0] e, input logic [31:0] g);
		return (g + 32'h1 >= e) && (g <= e + 32'h1);
	endfunction
	// One bus transfer; the last of a burst releases the bus for one cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic last, output logic [31:0] rd);
		int k;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		k = 0;
		do
		begin
			@(posedge ref_clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 50);
		if (pready_o !== 1'b1)
			n_fail++;
		rd = prdata_o;
		penable_i <= 1'b0;
		if (last)
		begin
			psel_i <= 1'b0;
			@(posedge ref_clk_i);
		end
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		@(negedge ref_clk_i);
		while (irq_o !== 1'b1 && n < lim)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		@(posedge ref_clk_i);
	endtask
	// Two acquisitions, so the second covers a whole period
	task automatic acq();
		repeat (2)
		begin
			apb(1'b1, `PMT_OFF_IRQ_CLR, 32'h3, 1'b1, q);
			wait_irq(600);
		end
		`CHK("acq_irq", 1'b1, n < 600)
	endtask
	task automatic finish_test();
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		@(posedge ref_clk_i);
		for (i = 0; i < 3; i++)
		begin
			apb(1'b0, `PMT_OFF_PR_LOW + 12'(4 * i), 32'h0, 1'b1, q);
			`CHK("pr_reset", 8'hFF, q[7:0])
		end
		apb(1'b0, 12'h038, 32'h0, 1'b1, q);
		`CHK("unmapped", 32'h0, q)
		// Counter and match bytes written and read back to back
		for (i = 0; i < 6; i++)
		begin
			d = rnd();
			apb(1'b1, `PMT_OFF_CNT_LOW + 12'(4 * i), d, 1'b0, q);
			apb(1'b0, `PMT_OFF_CNT_LOW + 12'(4 * i), 32'h0, 1'b1, q);
			`CHK("byte_rw", d[7:0], q[7:0])
		end
		// Level of each selectable gate source
		gate_lvl <= 4'(rnd());
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, `PMT_OFF_SEL, 32'(i << 2), 1'b1, q);
			apb(1'b0, `PMT_OFF_LEVELS, 32'h0, 1'b1, q);
			`CHK("gate_level", gate_lvl[i], q[0])
		end
		// Match value 6 with the upper byte high: only the 16-bit width matches
		gate_lvl <= 4'hF;
		for (i = 0; i < 6; i++)
			apb(1'b1, 12'h008 + 12'(4 * i), (i == 3) ? 32'h6 : (i == 5) ? 32'hFF : 32'h0,
				1'b1, q);
		apb(1'b1, `PMT_OFF_IRQ_EN, 32'h1, 1'b1, q);
		apb(1'b1, `PMT_OFF_CTRL, 32'h3, 1'b1, q);
		wait_irq(40);
		`CHK("no_match_24", 1'b1, n == 40)
		apb(1'b1, `PMT_OFF_CTRL, 32'h0, 1'b1, q);
		apb(1'b1, `PMT_OFF_CNT_LOW, 32'h0, 1'b1, q);
		apb(1'b1, `PMT_OFF_CTRL, 32'h13, 1'b1, q);
		wait_irq(600);
		`CHK("match_time", 1'b1, n >= 8 && n <= 20)
		apb(1'b0, `PMT_OFF_STATUS, 32'h0, 1'b1, q);
		`CHK("st_match", 1'b1, q[0])
		apb(1'b1, `PMT_OFF_IRQ_EN, 32'h0, 1'b1, q);
		apb(1'b1, `PMT_OFF_CTRL, 32'h0, 1'b1, q);
		apb(1'b1, `PMT_OFF_IRQ_CLR, 32'h3, 1'b1, q);
		apb(1'b0, `PMT_OFF_STATUS, 32'h0, 1'b1, q);
		`CHK("st_clear", 2'b00, q[1:0])
		// Duty cycle runs in both polarities, each followed by a single acquisition
		apb(1'b1, `PMT_OFF_SEL, 32'h40, 1'b1, q);
		apb(1'b1, `PMT_OFF_IRQ_EN, 32'h2, 1'b1, q);
		for (i = 0; i < 4; i++)
		begin
			hi <= 8'(6 + 2 * (rnd() % 16));
			lo <= 8'(6 + 2 * (rnd() % 16));
			apb(1'b1, `PMT_OFF_CTRL, 32'h23 | (32'(i % 2) << 3), 1'b1, q);
			acq();
			d = (i % 2) ? lo : hi;
			apb(1'b0, `PMT_OFF_PW_CAP, 32'h0, 1'b1, q);
			`CHK("pw_cap", 1'b1, near(1 + d / 2, q))
			apb(1'b0, `PMT_OFF_PER_CAP, 32'h0, 1'b1, q);
			`CHK("per_cap", 1'b1, near(1 + (hi + lo) / 2, q))
			apb(1'b1, `PMT_OFF_CTRL, 32'h27 | (32'(i % 2) << 3), 1'b1, q);
			apb(1'b1, `PMT_OFF_IRQ_CLR, 32'h3, 1'b1, q);
			wait_irq(600);
			apb(1'b0, `PMT_OFF_CTRL, 32'h0, 1'b1, q);
			`CHK("go_cleared", 2'b01, q[1:0])
		end
		// Relative timing to a window rising 8 cycles after the measured rise
		hi <= 8'h0A;
		lo <= 8'h0A;
		apb(1'b1, `PMT_OFF_CTRL, 32'h43, 1'b1, q);
		acq();
		apb(1'b0, `PMT_OFF_PW_CAP, 32'h0, 1'b1, q);
		`CHK("rel_cap", 1'b1, near(32'h5, q))
		finish_test();
	end
endmodule // pulse_measure_timer_test
bind pulse_measure_timer pulse_measure_timer_sva pulse_measure_timer_sva_i (.ref_clk_i,
	.reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .irq_o);
